// [core/bbm_bus_break_matcher.sv]
// bus break matcher: compares internal bus cycles with break conditions
// Summary of operation
// R1: fetch break precedes instruction, pc is address
// R2: select 0054 means cpu fetch read
// R3: 006a cpu data word write, 0066 read
// R4: 00a7 means dma data read longword
// R5: fetch with write direction never matches
// R6: odd fetch address never matches normal fetches
// R7: odd branch target breaks after address error
// R8: word condition on odd address never matches
// R9: dma with fetch never matches
// R10: second paired fetch uses old condition
// R11: overrun fetches precede taken branch destination
// R12: overrun fetches raise no fetch break
// R13: overrun fetch matches data conditions too
// R14: break lost on higher exception may vanish
// R15: software avoids breaks on destination fetches
// R16: even first destination fetch after branch never breaks
// R17: matches drive active low trigger pin
// R18: new match restarts pulse, pin stays low
// R19: overrun fetch match on a fetch-only condition pulses trigger only
// R20: data and dma matches trigger as interrupts
// R21: irq disable still allows trigger pulses
// R22: power-on reset enters module standby
// R23: software leaves standby before writing conditions
// R24: width select gives 1, 4, 8, 16 clocks
// R25: a zero cpu/dma, fetch/data or read/write select pair blocks breaks; zero size means any size
// R26: break request carries priority level fifteen
// R27: address and attributes must match together
`timescale 1ns/1ps
`default_nettype none
`include "bbm_regs.svh"
module bbm_bus_break_matcher (
  input  wire logic                SYS_CLK,
  input  wire logic                NRST,
  input  wire logic                MODULE_STANDBY_CTRL,
  input  wire logic [31:0]         BREAK_ADDR,
  input  wire logic [31:0]         BREAK_ADDR_MASK,
  input  wire logic [15:0]         BREAK_CYCLE_SELECT,
  input  wire logic [15:0]         BREAK_CONTROL,
  input  wire logic                COND_WRITE,
  input  wire bbm_pkg::bbm_cycle_t BUS_CYCLE,
  input  wire logic                BREAK_ACK,
  input  wire logic                EXC_ABORT,
  output logic                     BREAK_REQ,
  output logic [3:0]               BREAK_LEVEL,
  output logic [31:0]              BREAK_PC,
  output logic                     BREAK_AFTER_ADDR_ERR,
  output logic [15:0]              BREAK_CONTROL_RD,
  output logic                     IN_STANDBY,
  output logic                     MATCH_TRIGGER_OUT_N
);
  logic        rst_s1_reg;
  logic        rst_s2_reg;
  logic        rst_n;
  logic [31:0] addr_reg;
  logic [31:0] mask_reg;
  logic [15:0] sel_reg;
  logic [15:0] ctl_reg;
  logic        raw_match;
  logic        data_match;
  logic        as_fetch;
  logic        dest_block;
  logic        irq_off;
  logic        req_set;
  logic        req_clr;
  logic [1:0]  cks_sel;
  logic        irq_match;
  logic        trig_match;
  logic [4:0]  width;
  logic [4:0]  cnt_reg;
  logic [4:0]  cnt_next;
  bbm_pkg::bbm_state_t state_reg;
  bbm_pkg::bbm_state_t state_next;

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  assign rst_n = rst_s2_reg;

  ////////////////////////////////////////////////////////////////////////////
  // select pair check: 00 disables, 11 accepts both, else must agree
  function automatic logic pair_ok(input logic [1:0] sel, input logic second);
    case (sel)
      2'h1:    pair_ok = !second;
      2'h2:    pair_ok = second;
      2'h3:    pair_ok = 1'h1;
      default: pair_ok = 1'h0; // R25
    endcase
  endfunction

  function automatic logic [4:0] width_of(input logic [1:0] cks);
    case (cks)
      2'h0: begin
        width_of = 5'(`BBM_WIDTH_DIV1);
      end
      2'h1: begin
        width_of = 5'(`BBM_WIDTH_DIV4);
      end
      2'h2: begin
        width_of = 5'(`BBM_WIDTH_DIV8);
      end
      default: begin
        width_of = 5'(`BBM_WIDTH_DIV16);
      end
    endcase
  endfunction

  function automatic logic size_ok(input logic [1:0] szsel, input bbm_pkg::bbm_size_t size);
    size_ok = (szsel == 2'h0) || (szsel == size);
  endfunction

  // a set mask bit drops that address bit from the compare
  function automatic logic addr_hit(input logic [31:0] addr,
                                    input logic [31:0] ref_addr,
                                    input logic [31:0] ign);
    addr_hit = ((addr ^ ref_addr) & ~ign) == 32'h0000_0000;
  endfunction

  // full condition test; fetch_flag says whether the cycle is judged as a fetch
  function automatic logic cond_hit(input logic [15:0]         sel,
                                    input bbm_pkg::bbm_cycle_t cyc,
                                    input logic                fetch_flag,
                                    input logic [31:0]         ref_addr,
                                    input logic [31:0]         ign);
    logic own_ok;
    logic kind_ok;
    logic dir_ok;
    own_ok   = pair_ok(sel[`BBM_SEL_CP_LSB +: 2], cyc.is_dma);
    kind_ok  = pair_ok(sel[`BBM_SEL_ID_LSB +: 2], !fetch_flag);
    dir_ok   = pair_ok(sel[`BBM_SEL_RW_LSB +: 2], cyc.is_write);
    cond_hit = cyc.valid && addr_hit(cyc.addr, ref_addr, ign)
               && size_ok(sel[`BBM_SEL_SZ_LSB +: 2], cyc.size)
               && own_ok && kind_ok && dir_ok;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // condition registers, cleared in standby; writes land only outside standby
  // a write takes effect next cycle, so a cycle already on the bus is judged on the old value
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      addr_reg <= `BBM_ADDR_RESET;
    end else if (MODULE_STANDBY_CTRL) begin
      addr_reg <= `BBM_ADDR_RESET;
    end else if (COND_WRITE) begin // R10 R23
      addr_reg <= BREAK_ADDR;
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      mask_reg <= `BBM_MASK_RESET;
    end else if (MODULE_STANDBY_CTRL) begin
      mask_reg <= `BBM_MASK_RESET;
    end else if (COND_WRITE) begin // R10 R23
      mask_reg <= BREAK_ADDR_MASK;
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      sel_reg <= `BBM_SEL_RESET;
    end else if (MODULE_STANDBY_CTRL) begin
      sel_reg <= `BBM_SEL_RESET;
    end else if (COND_WRITE) begin // R10 R23
      sel_reg <= {8'h00, BREAK_CYCLE_SELECT[7:0]};
    end
  end

  // only the three defined control bits are kept; the rest read zero
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ctl_reg <= `BBM_CTL_RESET;
    end else if (MODULE_STANDBY_CTRL) begin
      ctl_reg <= `BBM_CTL_RESET;
    end else if (COND_WRITE) begin // R10 R23
      ctl_reg <= {13'h0, BREAK_CONTROL[2:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // match decode; an overrun fetch counts as a data access
  assign as_fetch   = BUS_CYCLE.is_fetch && !BUS_CYCLE.overrun; // R13 R11
  // fetches never carry write or dma attributes, so 0058 and 0094 stay silent
  // the trigger judges the cycle as it stands on the bus, overrun fetches too
  assign raw_match  = !MODULE_STANDBY_CTRL
                      && cond_hit(sel_reg, BUS_CYCLE, BUS_CYCLE.is_fetch, addr_reg, mask_reg); // R27 R2 R3 R4 R5 R9
  assign data_match = !MODULE_STANDBY_CTRL
                      && cond_hit(sel_reg, BUS_CYCLE, as_fetch, addr_reg, mask_reg); // R13 R12 R25
  // an odd first destination fetch still breaks, after the address error
  assign dest_block = as_fetch && BUS_CYCLE.first_dest && !BUS_CYCLE.addr[0]; // R16 R7
  assign irq_off    = ctl_reg[`BBM_CTL_IRQDIS_BIT]; // R21
  // odd normal fetch addresses and odd word addresses never appear on the bus
  assign trig_match = raw_match || data_match; // R6 R8 R17 R19 R20
  assign irq_match  = data_match && !dest_block && !irq_off; // R12 R16 R21

  ////////////////////////////////////////////////////////////////////////////
  // break request held until accepted, aborted or in standby; pc is the matched address
  // a new match in the accept cycle wins, so that break is never lost
  assign req_set = irq_match; // R1
  assign req_clr = BREAK_ACK || EXC_ABORT || MODULE_STANDBY_CTRL; // R14

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      BREAK_REQ <= 1'h0;
    end else if (req_set) begin // R1
      BREAK_REQ <= 1'h1;
    end else if (req_clr) begin // R14
      BREAK_REQ <= 1'h0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      BREAK_PC <= 32'h0000_0000;
    end else if (req_set) begin // R1
      BREAK_PC <= BUS_CYCLE.addr;
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      BREAK_AFTER_ADDR_ERR <= 1'h0;
    end else if (req_set) begin // R7
      BREAK_AFTER_ADDR_ERR <= BUS_CYCLE.is_fetch && BUS_CYCLE.addr[0];
    end else if (req_clr) begin
      BREAK_AFTER_ADDR_ERR <= 1'h0;
    end
  end
  assign BREAK_LEVEL = `BBM_IRQ_LEVEL; // R26

  ////////////////////////////////////////////////////////////////////////////
  // trigger pulse machine
  assign cks_sel = ctl_reg[`BBM_CTL_CKS_LSB +: 2];
  assign width   = width_of(cks_sel); // R24

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      bbm_pkg::BBM_ST_STANDBY: begin
        if (!MODULE_STANDBY_CTRL) begin
          state_next = bbm_pkg::BBM_ST_IDLE;
        end
      end
      bbm_pkg::BBM_ST_IDLE: begin
        if (MODULE_STANDBY_CTRL) begin
          state_next = bbm_pkg::BBM_ST_STANDBY;
        end else if (trig_match) begin // R17
          state_next = bbm_pkg::BBM_ST_PULSE;
          cnt_next   = width - 5'd1;
        end
      end
      bbm_pkg::BBM_ST_PULSE: begin
        if (MODULE_STANDBY_CTRL) begin
          state_next = bbm_pkg::BBM_ST_STANDBY;
        end else if (trig_match) begin // R18
          cnt_next = width - 5'd1;
        end else if (cnt_reg == 5'd0) begin
          state_next = bbm_pkg::BBM_ST_IDLE;
        end else begin
          cnt_next = cnt_reg - 5'd1;
        end
      end
      default: begin
        state_next = bbm_pkg::BBM_ST_STANDBY;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= bbm_pkg::BBM_ST_STANDBY; // R22
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 5'h0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      MATCH_TRIGGER_OUT_N <= 1'b1;
    end else begin
      MATCH_TRIGGER_OUT_N <= !(state_next == bbm_pkg::BBM_ST_PULSE);
    end
  end

  assign BREAK_CONTROL_RD = ctl_reg;
  assign IN_STANDBY       = (state_reg == bbm_pkg::BBM_ST_STANDBY);
endmodule
`default_nettype wire

// [core/bbm_regs.svh]
// field positions, reset values and timing counts for the bus break matcher
`ifndef BBM_REGS_SVH
`define BBM_REGS_SVH
`define BBM_SEL_SZ_LSB      0
`define BBM_SEL_RW_LSB      2
`define BBM_SEL_ID_LSB      4
`define BBM_SEL_CP_LSB      6
`define BBM_CTL_IRQDIS_BIT  0
`define BBM_CTL_CKS_LSB     1
`define BBM_CTL_RESET       16'h0000
`define BBM_SEL_RESET       16'h0000
`define BBM_ADDR_RESET      32'h0000_0000
`define BBM_MASK_RESET      32'h0000_0000
`define BBM_IRQ_LEVEL       4'hf
`define BBM_SYS_PERIOD_NS   4
`define BBM_WIDTH_DIV1      1
`define BBM_WIDTH_DIV4      4
`define BBM_WIDTH_DIV8      8
`define BBM_WIDTH_DIV16     16
`endif

// [core/bbm_pkg.sv]
// types shared by the bus break matcher
package bbm_pkg;
  typedef enum logic [1:0] {
    BBM_OWN_NONE = 2'b00,
    BBM_OWN_CPU  = 2'b01,
    BBM_OWN_DMA  = 2'b10,
    BBM_OWN_ANY  = 2'b11
  } bbm_sel2_t;

  typedef enum logic [1:0] {
    BBM_SZ_ANY  = 2'b00,
    BBM_SZ_BYTE = 2'b01,
    BBM_SZ_WORD = 2'b10,
    BBM_SZ_LONG = 2'b11
  } bbm_size_t;

  // one observed bus cycle
  typedef struct packed {
    logic        valid;
    logic        is_dma;
    logic        is_fetch;
    logic        is_write;
    bbm_size_t   size;
    logic        overrun;
    logic        first_dest;
    logic [31:0] addr;
  } bbm_cycle_t;

  typedef enum logic [1:0] {
    BBM_ST_STANDBY = 2'b00,
    BBM_ST_IDLE    = 2'b01,
    BBM_ST_PULSE   = 2'b10
  } bbm_state_t;
endpackage

// [verif/bbm_bus_model.sv]
// bus and interrupt controller model on the far side of the break matcher
`timescale 1ns/1ps
`default_nettype none
module bbm_bus_model (
  input  wire logic          clk,
  input  wire logic          req,
  input  wire logic [3:0]    lvl,
  input  wire logic [3:0]    mask,
  output bbm_pkg::bbm_cycle_t bus,
  output logic               ack
);
  bbm_pkg::bbm_cycle_t pend = '0;
  initial bus = '0;
  initial ack = 1'h0;
  // waits for a rising edge so a call never races the negedge pickup
  task put(input logic [39:0] c);
    @(posedge clk);
    pend = c;
  endtask
  // a released bus inverts the address it shows on each idle cycle, so the old one comes back every second cycle
  always @(negedge clk) begin
    bus <= pend.valid ? pend : bbm_pkg::bbm_cycle_t'({8'h00, ~bus.addr});
    pend = '0;
    ack <= req && !ack && lvl > mask;
  end
endmodule
`default_nettype wire

// [verif/bbm_asserts.sv]
// assertions on the bus break matcher ports
`timescale 1ns/1ps
`default_nettype none
module bbm_asserts (
  input wire logic                SYS_CLK,
  input wire logic                NRST,
  input wire logic                MODULE_STANDBY_CTRL,
  input wire logic [15:0]         BREAK_CONTROL,
  input wire logic [15:0]         BREAK_CYCLE_SELECT,
  input wire logic                COND_WRITE,
  input wire bbm_pkg::bbm_cycle_t BUS_CYCLE,
  input wire logic                BREAK_ACK,
  input wire logic                EXC_ABORT,
  input wire logic                BREAK_REQ,
  input wire logic [3:0]          BREAK_LEVEL,
  input wire logic [31:0]         BREAK_PC,
  input wire logic [15:0]         BREAK_CONTROL_RD,
  input wire logic                IN_STANDBY,
  input wire logic                MATCH_TRIGGER_OUT_N
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  // fetch/data select as the design holds it
  logic [1:0] kind_sel_seen;
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      kind_sel_seen <= 2'h0;
    end else if (MODULE_STANDBY_CTRL) begin
      kind_sel_seen <= 2'h0;
    end else if (COND_WRITE) begin
      kind_sel_seen <= BREAK_CYCLE_SELECT[5:4];
    end
  end
  AST_LEVEL: assert property (BREAK_LEVEL == 4'hf) else $error("bad level");
  AST_PC: assert property ($rose(BREAK_REQ) |-> BREAK_PC == $past(BUS_CYCLE.addr) && !MATCH_TRIGGER_OUT_N)
    else $error("bad pc");
  AST_TRIG_SRC: assert property (!BUS_CYCLE.valid && MATCH_TRIGGER_OUT_N |=> MATCH_TRIGGER_OUT_N)
    else $error("trigger without match");
  AST_W1: assert property ($fell(MATCH_TRIGGER_OUT_N) && BREAK_CONTROL_RD[2:1] == 2'h0 && !BUS_CYCLE.valid
    |=> MATCH_TRIGGER_OUT_N) else $error("pulse too long");
  AST_WN: assert property ($fell(MATCH_TRIGGER_OUT_N) && BREAK_CONTROL_RD[2:1] != 2'h0
    |-> !MATCH_TRIGGER_OUT_N [*4]) else $error("pulse too short");
  AST_IRQDIS: assert property (BREAK_CONTROL_RD[0] && !BREAK_REQ |=> !BREAK_REQ) else $error("req");
  AST_OVERRUN: assert property (BUS_CYCLE.valid && BUS_CYCLE.overrun && kind_sel_seen == 2'h1 && !BREAK_REQ
    |=> !BREAK_REQ)
    else $error("overrun req");
  AST_FIRST: assert property (BUS_CYCLE.valid && BUS_CYCLE.is_fetch && BUS_CYCLE.first_dest && !BUS_CYCLE.overrun &&
    !BUS_CYCLE.addr[0] && !BREAK_REQ |=> !BREAK_REQ) else $error("dest req");
  AST_DROP: assert property ((BREAK_ACK || EXC_ABORT) && !BUS_CYCLE.valid |=> !BREAK_REQ)
    else $error("req kept");
  AST_STBY: assert property (MODULE_STANDBY_CTRL |=> IN_STANDBY && !BREAK_REQ) else $error("stby");
  AST_CTRL: assert property (COND_WRITE && !IN_STANDBY && !MODULE_STANDBY_CTRL
    |=> BREAK_CONTROL_RD == ($past(BREAK_CONTROL) & 16'h0007)) else $error("ctrl");
endmodule
bind bbm_bus_break_matcher bbm_asserts u_bbm_asserts (
  .SYS_CLK(SYS_CLK), .NRST(NRST), .MODULE_STANDBY_CTRL(MODULE_STANDBY_CTRL), .BREAK_CONTROL(BREAK_CONTROL),
  .BREAK_CYCLE_SELECT(BREAK_CYCLE_SELECT), .COND_WRITE(COND_WRITE), .BUS_CYCLE(BUS_CYCLE),
  .BREAK_ACK(BREAK_ACK), .EXC_ABORT(EXC_ABORT), .BREAK_REQ(BREAK_REQ), .BREAK_LEVEL(BREAK_LEVEL),
  .BREAK_PC(BREAK_PC), .BREAK_CONTROL_RD(BREAK_CONTROL_RD), .IN_STANDBY(IN_STANDBY),
  .MATCH_TRIGGER_OUT_N(MATCH_TRIGGER_OUT_N));
`default_nettype wire

// [verif/bbm_bus_break_matcher_tb.sv]
// self-checking bench for the bus break matcher
`timescale 1ns/1ps
`default_nettype none
module bbm_bus_break_matcher_tb;
  logic                SYS_CLK = 1'h0, NRST = 1'h0, MODULE_STANDBY_CTRL = 1'h1, COND_WRITE = 1'h0, EXC_ABORT = 1'h0;
  logic [31:0]         BREAK_ADDR = '0, BREAK_ADDR_MASK = '0, BREAK_PC;
  logic [15:0]         BREAK_CYCLE_SELECT = '0, BREAK_CONTROL = '0, BREAK_CONTROL_RD;
  logic                BREAK_REQ, BREAK_ACK, BREAK_AFTER_ADDR_ERR, IN_STANDBY, MATCH_TRIGGER_OUT_N;
  logic [3:0]          BREAK_LEVEL, mask = 4'hf;
  bbm_pkg::bbm_cycle_t BUS_CYCLE;
  int                  n_fail = 0, cmp_count = 0, cyc = 0, n;
  bbm_bus_break_matcher u_bbm_bus_break_matcher (
    .SYS_CLK(SYS_CLK), .NRST(NRST), .MODULE_STANDBY_CTRL(MODULE_STANDBY_CTRL), .BREAK_ADDR(BREAK_ADDR),
    .BREAK_ADDR_MASK(BREAK_ADDR_MASK), .BREAK_CYCLE_SELECT(BREAK_CYCLE_SELECT), .BREAK_CONTROL(BREAK_CONTROL),
    .COND_WRITE(COND_WRITE), .BUS_CYCLE(BUS_CYCLE), .BREAK_ACK(BREAK_ACK), .EXC_ABORT(EXC_ABORT),
    .BREAK_REQ(BREAK_REQ), .BREAK_LEVEL(BREAK_LEVEL), .BREAK_PC(BREAK_PC),
    .BREAK_AFTER_ADDR_ERR(BREAK_AFTER_ADDR_ERR), .BREAK_CONTROL_RD(BREAK_CONTROL_RD), .IN_STANDBY(IN_STANDBY),
    .MATCH_TRIGGER_OUT_N(MATCH_TRIGGER_OUT_N));
  bbm_bus_model u_bbm_bus_model (.clk(SYS_CLK), .req(BREAK_REQ), .lvl(BREAK_LEVEL), .mask(mask),
    .bus(BUS_CYCLE), .ack(BREAK_ACK));
  initial forever #2 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] g, e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input logic [31:0] a, m, input logic [15:0] s, c);
    @(negedge SYS_CLK);
    {BREAK_ADDR, BREAK_ADDR_MASK, BREAK_CYCLE_SELECT, BREAK_CONTROL, COND_WRITE} = {a, m, s, c, 1'h1};
    @(negedge SYS_CLK);
    COND_WRITE = 1'h0;
  endtask
  // one condition and one bus cycle; a higher exception then drops the request
  task tc(input logic [31:0] a, input logic [15:0] s, c, input logic [39:0] b, input logic er, et);
    wr(a, 32'h0, s, c);
    u_bbm_bus_model.put(b);
    repeat (2) @(negedge SYS_CLK);
    chk(BREAK_REQ, er);
    chk(MATCH_TRIGGER_OUT_N, !et);
    if (er) chk(BREAK_PC, b[31:0]);
    chk(BREAK_AFTER_ADDR_ERR, er && b[37] && b[0]);
    EXC_ABORT = 1'h1;
    @(negedge SYS_CLK);
    EXC_ABORT = 1'h0;
    chk(BREAK_REQ, 1'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(negedge SYS_CLK);
    NRST = 1'h1;
    repeat (3) @(negedge SYS_CLK);
    wr(32'h404, 32'h0, 16'h0054, 16'h0007);
    chk(IN_STANDBY, 1'h1);
    chk(BREAK_CONTROL_RD, 16'h0);
    MODULE_STANDBY_CTRL = 1'h0;
    repeat (2) @(negedge SYS_CLK);
    $display("standby test done");
    tc(32'h404, 16'h0054, 16'h0, {8'ha8, 32'h404}, 1'h1, 1'h1);
    tc(32'h15389c, 16'h0058, 16'h0, {8'ha8, 32'h15389c}, 1'h0, 1'h0);
    tc(32'h30147, 16'h0054, 16'h0, {8'ha8, 32'h30146}, 1'h0, 1'h0);
    tc(32'h123456, 16'h006a, 16'h0, {8'h98, 32'h123456}, 1'h1, 1'h1);
    tc(32'h123456, 16'h0066, 16'h0, {8'h88, 32'h123456}, 1'h1, 1'h1);
    tc(32'ha80391, 16'h0066, 16'h0, {8'h88, 32'ha80390}, 1'h0, 1'h0);
    tc(32'h76bcdc, 16'h00a7, 16'h0, {8'hcc, 32'h76bcdc}, 1'h1, 1'h1);
    tc(32'h2345c8, 16'h0094, 16'h0, {8'hcc, 32'h2345c8}, 1'h0, 1'h0);
    tc(32'h123456, 16'h006a, 16'h0001, {8'h98, 32'h123456}, 1'h0, 1'h1);
    tc(32'h404, 16'h0014, 16'h0, {8'ha8, 32'h404}, 1'h0, 1'h0);
    tc(32'h404, 16'h0054, 16'h0, {8'haa, 32'h404}, 1'h0, 1'h1);
    tc(32'h404, 16'h0074, 16'h0, {8'haa, 32'h404}, 1'h1, 1'h1);
    tc(32'h404, 16'h0054, 16'h0, {8'ha9, 32'h404}, 1'h0, 1'h1);
    tc(32'h30147, 16'h0054, 16'h0, {8'ha9, 32'h30147}, 1'h1, 1'h1);
    $display("condition table done");
    wr(32'h404, 32'h0, 16'h0054, 16'h0);
    u_bbm_bus_model.put({8'ha8, 32'h404});
    wr(32'h0, 32'h0, 16'h0, 16'h0);
    chk(BREAK_REQ, 1'h1);
    repeat (4) @(negedge SYS_CLK);
    chk(BREAK_REQ, 1'h1);
    mask = 4'he;
    repeat (3) @(negedge SYS_CLK);
    chk(BREAK_REQ, 1'h0);
    u_bbm_bus_model.put({8'ha9, 32'h404});
    $display("pending request done");
    for (int k = 0; k < 4; k++) begin
      wr(32'h404, 32'h0, 16'h0054, 16'(2 * k + 1));
      u_bbm_bus_model.put({8'ha8, 32'h404});
      u_bbm_bus_model.put({8'ha8, 32'h404});
      n = 0;
      repeat (24) begin
        @(negedge SYS_CLK);
        n += (MATCH_TRIGGER_OUT_N === 1'h0);
      end
      chk(n, k == 0 ? 2 : (2 << k) + 1);
    end
    $display("trigger width done");
    MODULE_STANDBY_CTRL = 1'h1;
    repeat (2) @(negedge SYS_CLK);
    chk(IN_STANDBY, 1'h1);
    chk(BREAK_CONTROL_RD, 16'h0);
    conclude();
  end
endmodule
`default_nettype wire
